// File: rtl/prc_top.sv
// Reset, suspend and output-float control for the bus-side logic
`timescale 1ns/1ps
`include "prc_consts.svh"

module prc_top
  import prc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic global_reset_in,
  input wire logic bus_reset_in,
  input wire logic suspend_in,
  input wire prc_pkg::prc_wr_t wr,
  input wire logic [`PRC_IDX_W-1:0] rd_idx,
  input wire logic drive_req,
  input wire logic [`PRC_IDX_W-1:0] drive_idx,
  output prc_pkg::prc_pin_t pin,
  output logic [`PRC_DATA_W-1:0] rd_data,
  output logic ready,
  output logic suspended
);
  import prc_pkg::*;

  // --------------------------------------------------------------------------
  // Reset decode
  // --------------------------------------------------------------------------
  // Global reset outranks suspend; suspend only shields the bus reset
  function automatic prc_state_t next_state(input logic g, input logic b,
                                            input logic s);
    prc_state_t st;
    st = PRC_ST_RUN;
    if (g) begin
      st = PRC_ST_RESET;
    end else if (b && s) begin
      st = PRC_ST_SUSP;
    end else if (b) begin
      st = PRC_ST_RESET;
    end
    return st;
  endfunction : next_state

  function automatic logic must_clear(input logic g, input logic b,
                                      input logic s);
    return g || (b && !s);
  endfunction : must_clear

  prc_state_t state_r;
  prc_state_t state_nxt;
  logic clr;
  logic floating;
  prc_wr_t wr_gated;
  prc_bank_t bank_q;

  // All inputs are used straight from the clock edge; no synchronisers
  always_comb begin
    state_nxt = next_state(global_reset_in, bus_reset_in, suspend_in);
    clr = must_clear(global_reset_in, bus_reset_in, suspend_in);
    floating = global_reset_in || bus_reset_in;
    wr_gated = wr;
    // Writes only while running and no reset is present this cycle
    wr_gated.en = wr.en && (state_r == PRC_ST_RUN) && !floating;
  end

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= PRC_ST_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Register storage
  // --------------------------------------------------------------------------
  prc_reg_bank u_bank (
    .core_clk(core_clk),
    .rstn(rstn),
    .clr(clr),
    .wr(wr_gated),
    .q(bank_q)
  );

  // --------------------------------------------------------------------------
  // Pin drivers
  // --------------------------------------------------------------------------
  // Enable drops in the same edge that sees a reset, so the pin never
  // drives for a cycle after reset is seen
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pin.oe <= 1'b0;
      pin.dout <= `PRC_PIN_RST;
    end else if (state_nxt != PRC_ST_RUN) begin
      pin.oe <= 1'b0;
      pin.dout <= `PRC_PIN_RST;
    end else begin
      pin.oe <= drive_req;
      pin.dout <= bank_q[drive_idx];
    end
  end

  // --------------------------------------------------------------------------
  // Read-back and status
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rd_data <= `PRC_REG_RST;
    end else if (state_nxt != PRC_ST_RUN) begin
      rd_data <= `PRC_REG_RST;
    end else begin
      rd_data <= bank_q[rd_idx];
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ready <= 1'b0;
    end else begin
      ready <= (state_nxt == PRC_ST_RUN);
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      suspended <= 1'b0;
    end else begin
      suspended <= (state_nxt == PRC_ST_SUSP);
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  property p_global_reset_in_float;
    global_reset_in |=> !pin.oe && !ready && !suspended;
  endproperty
  a_global_reset_in_float: assert property (p_global_reset_in_float)
    else $error("pins driven or ready after global reset");

  property p_global_reset_in_clear;
    global_reset_in |=> (bank_q == '0) && (rd_data == '0);
  endproperty
  a_global_reset_in_clear: assert property (p_global_reset_in_clear)
    else $error("registers not cleared by global reset");

  property p_sample_write;
    logic [`PRC_IDX_W-1:0] i;
    logic [`PRC_DATA_W-1:0] d;
    (wr.en && ready && !global_reset_in && !bus_reset_in, i = wr.idx,
      d = wr.data) |=> bank_q[i] == d;
  endproperty
  a_sample_write: assert property (p_sample_write)
    else $error("write taken at clock edge was not stored");

  property p_bus_reset_in_clear;
    bus_reset_in && !suspend_in |=> (bank_q == '0) && !pin.oe && !ready;
  endproperty
  a_bus_reset_in_clear: assert property (p_bus_reset_in_clear)
    else $error("bus reset without suspend did not clear and float");

  sequence s_bus_reset_held;
    bus_reset_in && !global_reset_in;
  endsequence

  sequence s_release;
    !bus_reset_in && !global_reset_in;
  endsequence

  property p_release_ready;
    s_bus_reset_held ##1 s_release |=> ready && !suspended;
  endproperty
  a_release_ready: assert property (p_release_ready)
    else $error("not ready one cycle after bus reset release");

  property p_suspend_keep;
    bus_reset_in && suspend_in && !global_reset_in |=>
      (bank_q == $past(bank_q)) && !pin.oe && suspended && !ready;
  endproperty
  a_suspend_keep: assert property (p_suspend_keep)
    else $error("suspended bus reset changed registers or drove pins");

  property p_suspend_exit_keeps;
    bus_reset_in && suspend_in && !global_reset_in ##1 s_release |=>
      bank_q == $past(bank_q, 2);
  endproperty
  a_suspend_exit_keeps: assert property (p_suspend_exit_keeps)
    else $error("registers lost across suspend exit");

  property p_global_reset_in_beats_suspend;
    global_reset_in && suspend_in |=> (bank_q == '0) && !suspended;
  endproperty
  a_global_reset_in_beats_suspend: assert property (p_global_reset_in_beats_suspend)
    else $error("global reset failed to clear during suspend");

  // Sampled rstn keeps the edge that releases the async reset out of these
  property p_read_back;
    rstn && !global_reset_in && !bus_reset_in |=>
      rd_data == $past(bank_q[rd_idx]);
  endproperty
  a_read_back: assert property (p_read_back)
    else $error("read-back not taken at the rising edge");

  property p_pin_follow;
    rstn && !global_reset_in && !bus_reset_in |=>
      (pin.oe == $past(drive_req)) &&
      (pin.dout == $past(bank_q[drive_idx]));
  endproperty
  a_pin_follow: assert property (p_pin_follow)
    else $error("pins do not follow requests while running");

  property p_bus_reset_quiet;
    bus_reset_in |=> !pin.oe && !ready && (rd_data == '0) &&
      (pin.dout == `PRC_PIN_RST);
  endproperty
  a_bus_reset_quiet: assert property (p_bus_reset_quiet)
    else $error("outputs active while bus reset was seen");

  sequence s_suspend_seen;
    bus_reset_in && suspend_in && !global_reset_in;
  endsequence

  property p_suspend_hold;
    s_suspend_seen ##1 s_suspend_seen |=>
      suspended && !pin.oe && (rd_data == '0);
  endproperty
  a_suspend_hold: assert property (p_suspend_hold)
    else $error("held suspend did not keep outputs floating");

endmodule : prc_top

// File: common/prc_consts.svh
// Constants for the PCI-side reset domain control block
`ifndef PRC_CONSTS_SVH
`define PRC_CONSTS_SVH

// ----------------------------------------------------------------------------
// Storage geometry
// ----------------------------------------------------------------------------
`define PRC_NUM_REGS 4
`define PRC_IDX_W 2
`define PRC_DATA_W 8

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PRC_REG_RST 8'h00
`define PRC_PIN_RST 8'h00

`endif

// File: common/prc_pkg.sv
// Types shared by the reset domain control block
`include "prc_consts.svh"

package prc_pkg;

  typedef enum logic [1:0] {
    PRC_ST_RESET = 2'b00,
    PRC_ST_SUSP = 2'b01,
    PRC_ST_RUN = 2'b10
  } prc_state_t;

  typedef struct packed {
    logic en;
    logic [`PRC_IDX_W-1:0] idx;
    logic [`PRC_DATA_W-1:0] data;
  } prc_wr_t;

  typedef struct packed {
    logic oe;
    logic [`PRC_DATA_W-1:0] dout;
  } prc_pin_t;

  typedef logic [`PRC_NUM_REGS-1:0][`PRC_DATA_W-1:0] prc_bank_t;

endpackage : prc_pkg

// File: rtl/prc_reg_bank.sv
// Register bank that can be cleared or left untouched to retain contents
`timescale 1ns/1ps
`include "prc_consts.svh"

module prc_reg_bank
  import prc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clr,
  input wire prc_pkg::prc_wr_t wr,
  output prc_pkg::prc_bank_t q
);
  import prc_pkg::*;

  // --------------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------------
  // Retention is simply the absence of clr and wr.en; the caller gates both
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < `PRC_NUM_REGS; i++) begin
        q[i] <= `PRC_REG_RST;
      end
    end else if (clr) begin
      for (int i = 0; i < `PRC_NUM_REGS; i++) begin
        q[i] <= `PRC_REG_RST;
      end
    end else if (wr.en) begin
      q[wr.idx] <= wr.data;
    end
  end

endmodule : prc_reg_bank

// File: verification/prc_host_src.sv
// Host-side model of the bus reset, global reset and suspend sources
`timescale 1ns/1ps

module prc_host_src (
  input wire logic core_clk,
  input wire logic glob_req,
  input wire logic bus_req,
  input wire logic susp_req,
  output logic global_reset_in,
  output logic bus_reset_in,
  output logic suspend_in
);
  // ---------------------------------------------------------------------
  // Reset sources
  // ---------------------------------------------------------------------
  // Levels are known from time zero so the block never samples unknowns
  initial begin
    global_reset_in = 1'b0;
    bus_reset_in = 1'b0;
    suspend_in = 1'b0;
  end

  // A host moves its reset lines just after the bus clock edge
  always @(posedge core_clk) begin
    global_reset_in <= glob_req;
    bus_reset_in <= bus_req;
    suspend_in <= susp_req;
  end
endmodule : prc_host_src

// File: verification/prc_top_tb.sv
// Self-checking bench for the reset domain control block
`timescale 1ns/1ps

module prc_top_tb;
  import prc_pkg::*;
  logic core_clk, rstn, g_req, b_req, s_req, drive_req;
  logic global_reset_in, bus_reset_in, suspend_in, ready, suspended;
  logic [1:0] rd_idx, drive_idx;
  logic [7:0] rd_data, rnd;
  prc_wr_t wr;
  prc_pin_t pin;
  int failures, total_checks;
  int m_bank[4];
  int m_rd, m_dout;
  bit m_oe, m_rdy, m_susp;

  prc_host_src host (.core_clk(core_clk), .glob_req(g_req), .bus_req(b_req),
    .susp_req(s_req), .global_reset_in(global_reset_in),
    .bus_reset_in(bus_reset_in), .suspend_in(suspend_in));

  prc_top DUT (.core_clk(core_clk), .rstn(rstn),
    .global_reset_in(global_reset_in), .bus_reset_in(bus_reset_in),
    .suspend_in(suspend_in), .wr(wr), .rd_idx(rd_idx),
    .drive_req(drive_req), .drive_idx(drive_idx), .pin(pin),
    .rd_data(rd_data), .ready(ready), .suspended(suspended));

  // ---------------------------------------------------------------------
  // Reference model, sampled on the same rising edge as the block
  // ---------------------------------------------------------------------
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      foreach (m_bank[i]) m_bank[i] = 0;
      {m_oe, m_rdy, m_susp, m_rd, m_dout} = 0;
    end else if (global_reset_in || bus_reset_in) begin
      if (global_reset_in || !suspend_in) begin
        foreach (m_bank[i]) m_bank[i] = 0;
      end
      {m_oe, m_rdy, m_rd} = 0;
      m_susp = !global_reset_in && suspend_in;
    end else begin
      m_oe = drive_req;
      m_dout = m_bank[drive_idx];
      m_rd = m_bank[rd_idx];
      if (wr.en && m_rdy) m_bank[wr.idx] = wr.data;
      m_rdy = 1;
      m_susp = 0;
    end
  end

  task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // Outputs are settled by the falling edge
  always @(negedge core_clk) begin
    check("oe", 8'(pin.oe), 8'(m_oe));
    check("ready", 8'(ready), 8'(m_rdy));
    check("suspended", 8'(suspended), 8'(m_susp));
    check("rd_data", rd_data, 8'(m_rd));
    if (m_oe) check("dout", pin.dout, 8'(m_dout));
  end

  // ---------------------------------------------------------------------
  // Stimulus
  // ---------------------------------------------------------------------
  function automatic logic [7:0] lfsr(logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr

  task automatic test_done();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  // Suspend mode: 0 low, 1 high, 2 random
  task automatic run(int n, bit g, bit b, int s, string nm);
    repeat (n) begin
      @(posedge core_clk);
      rnd = lfsr(rnd);
      g_req <= g;
      b_req <= b;
      s_req <= (s == 2) ? rnd[6] : s[0];
      wr <= '{en: rnd[0], idx: rnd[2:1], data: lfsr(rnd) ^ 8'h5A};
      rd_idx <= rnd[4:3];
      drive_idx <= rnd[7:6];
      drive_req <= rnd[5];
    end
    $display("test %s done", nm);
  endtask : run

  task automatic wait_ready();
    for (int k = 0; k < 8; k++) begin
      @(negedge core_clk);
      if (ready === 1'b1) return;
    end
    failures++;
    test_done();
  endtask : wait_ready

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  initial begin
    {g_req, b_req, s_req, drive_req} = 4'h0;
    {rd_idx, drive_idx} = 4'h0;
    wr = '0;
    rnd = 8'h27;
    rstn = 1'b0;
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    wait_ready();
    run(40, 0, 0, 2, "writes and drive");
    run(3, 0, 1, 0, "bus reset clears");
    run(30, 0, 0, 2, "restart");
    run(4, 0, 1, 1, "suspend keeps");
    run(30, 0, 0, 0, "read after suspend");
    run(3, 1, 1, 1, "global over suspend");
    run(30, 0, 0, 2, "after global");
    run(2, 1, 0, 2, "global alone");
    run(20, 0, 0, 2, "after global alone");
    @(posedge core_clk);
    rstn <= 1'b0;
    run(2, 0, 0, 0, "async reset");
    rstn <= 1'b1;
    run(20, 0, 0, 2, "after async reset");
    test_done();
  end
endmodule : prc_top_tb
